// >>> hbcc_regs.svh
// Constants for the battery check, calendar alarm and clock configuration block.
`ifndef HBCC_REGS_SVH
`define HBCC_REGS_SVH
`define HBCC_WILDCARD 8'hff
`define HBCC_CHECK_CYCLES_DEF 16'h0010
`define HBCC_INTERVAL_DEF 32'h0000_8000
`define HBCC_MATCH_INDEX0 2'h0
`endif

// >>> hbcc_pkg.sv
// Types shared by the battery check, calendar alarm and clock configuration block.
package hbcc_pkg;
	typedef enum logic [2:0]
	{
		HBCC_MODE_RTC = 3'h1,
		HBCC_MODE_24H = 3'h2,
		HBCC_MODE_12H = 3'h4
	} hbcc_mode_t;

	typedef struct packed
	{
		logic [7:0] day;
		logic [7:0] hour;
		logic [7:0] minute;
		logic [7:0] second;
	} hbcc_cal_t;

	typedef struct packed
	{
		logic osc_power_down;
		logic crystal_drive_high;
		logic crystal_drive_low;
		logic select_internal_slow_osc;
		logic module_clock_to_system;
		logic [1:0] alt_clock_enable;
	} hbcc_clk_cfg_t;

	typedef enum logic [2:0]
	{
		HBCC_ST_IDLE = 3'h1,
		HBCC_ST_MEASURE = 3'h2,
		HBCC_ST_HIBERNATE = 3'h4
	} hbcc_state_t;
endpackage : hbcc_pkg

// >>> hbcc_core.sv
// Battery check, calendar alarm match and clock source configuration logic.
`timescale 1ns/10ps
`include "hbcc_regs.svh"

// Notes on behaviour
// - Forced check starts measuring immediately.
// - In-progress indication nonzero until measurement ends.
// - Low result sets sticky low battery flag.
// - Enabled low battery raises interrupt.
// - Hibernation request waits for check end.
// - Alarm field 0xff matches any value.
// - Oscillator disable powers down crystal oscillator.
// - Two crystal drive strengths, high and low.
// - With crystal fitted, pick a drive setting.
// - Option selects internal slow oscillator source.
// - Option routes module clock to system.
// - Alternate clock outputs gated by configuration.
// - Counter runs in exactly one mode.
module hbcc_core #(
	parameter int CHECK_CYCLES = 16,
	parameter int INTERVAL_CYCLES = 32768,
	parameter int ALT_OUTS = 2
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic force_check,
	input wire logic battery_low_in,
	input wire logic low_battery_int_en,
	input wire logic low_battery_clear,
	input wire logic hibernate_request,
	input wire logic [2:0] mode_sel,
	input wire logic second_tick,
	input wire hbcc_pkg::hbcc_cal_t cal_now,
	input wire hbcc_pkg::hbcc_cal_t alarm_value,
	input wire logic alarm_write,
	input wire logic [1:0] alarm_index,
	input wire logic alarm_clear,
	input wire hbcc_pkg::hbcc_clk_cfg_t clk_cfg_in,
	input wire logic clk_cfg_write,
	input wire logic crystal_clk,
	input wire logic external_osc_input,
	input wire logic internal_low_freq_osc,
	output logic check_busy,
	output logic measure_enable,
	output logic low_battery_flag,
	output logic low_battery_irq,
	output logic hibernate_go,
	output hbcc_pkg::hbcc_mode_t counter_mode,
	output logic calendar_mode_24h,
	output logic calendar_mode_12h,
	output logic alarm_match,
	output hbcc_pkg::hbcc_clk_cfg_t clk_cfg,
	output logic osc_enable,
	output logic module_clk,
	output logic sys_clk_out,
	output logic [ALT_OUTS-1:0] alt_clk_out
);
	// ------------------------------------------------------------
	// Battery check sequencer
	// ------------------------------------------------------------
	hbcc_pkg::hbcc_state_t state_reg, state_next;
	logic [15:0] meas_cnt_reg, meas_cnt_next;
	logic [31:0] intv_cnt_reg, intv_cnt_next;
	logic low_reg, low_next;
	logic hib_pend_reg, hib_pend_next;
	logic hib_go_reg, hib_go_next;

	always_comb
	begin
		state_next = state_reg;
		meas_cnt_next = meas_cnt_reg;
		intv_cnt_next = intv_cnt_reg + 32'h1;
		low_next = low_reg;
		hib_pend_next = hib_pend_reg | hibernate_request;
		hib_go_next = 1'b0;
		// A clear in the same cycle as a low result loses to the set.
		if (low_battery_clear)
			low_next = 1'b0;
		unique case (state_reg)
			hbcc_pkg::HBCC_ST_IDLE:
			begin
				if (force_check || intv_cnt_reg >= 32'(INTERVAL_CYCLES - 1))
				begin
					state_next = hbcc_pkg::HBCC_ST_MEASURE;
					meas_cnt_next = 16'h0;
					intv_cnt_next = 32'h0;
				end
				else if (hib_pend_next)
				begin
					state_next = hbcc_pkg::HBCC_ST_HIBERNATE;
				end
			end
			hbcc_pkg::HBCC_ST_MEASURE:
			begin
				meas_cnt_next = meas_cnt_reg + 16'h1;
				if (meas_cnt_reg >= 16'(CHECK_CYCLES - 1))
				begin
					state_next = hbcc_pkg::HBCC_ST_IDLE;
					if (battery_low_in)
						low_next = 1'b1;
				end
			end
			hbcc_pkg::HBCC_ST_HIBERNATE:
			begin
				hib_go_next = 1'b1;
				hib_pend_next = 1'b0;
				state_next = hbcc_pkg::HBCC_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= hbcc_pkg::HBCC_ST_IDLE;
			meas_cnt_reg <= 16'h0;
			intv_cnt_reg <= 32'h0;
			low_reg <= 1'b0;
			hib_pend_reg <= 1'b0;
			hib_go_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			meas_cnt_reg <= meas_cnt_next;
			intv_cnt_reg <= intv_cnt_next;
			low_reg <= low_next;
			hib_pend_reg <= hib_pend_next;
			hib_go_reg <= hib_go_next;
		end
	end

	assign check_busy = (state_reg == hbcc_pkg::HBCC_ST_MEASURE);
	assign measure_enable = check_busy;
	assign low_battery_flag = low_reg;
	assign low_battery_irq = low_reg & low_battery_int_en;
	assign hibernate_go = hib_go_reg;

	// ------------------------------------------------------------
	// Counter mode and calendar alarm
	// ------------------------------------------------------------
	hbcc_pkg::hbcc_mode_t mode_reg, mode_next;
	hbcc_pkg::hbcc_cal_t alarm_reg, alarm_next;
	logic match_reg, match_next;
	logic [3:0] field_hit;

	// Only one-hot mode codes are accepted; anything else keeps the old mode.
	always_comb
	begin
		mode_next = mode_reg;
		unique case (mode_sel)
			3'h1: mode_next = hbcc_pkg::HBCC_MODE_RTC;
			3'h2: mode_next = hbcc_pkg::HBCC_MODE_24H;
			3'h4: mode_next = hbcc_pkg::HBCC_MODE_12H;
			default: mode_next = mode_reg;
		endcase
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_field
			assign field_hit[gi] = (alarm_reg[gi*8 +: 8] == `HBCC_WILDCARD) ||
				(alarm_reg[gi*8 +: 8] == cal_now[gi*8 +: 8]);
		end
	endgenerate

	always_comb
	begin
		alarm_next = alarm_reg;
		// Writes to a nonzero index are dropped: only one match register exists.
		if (alarm_write && alarm_index == `HBCC_MATCH_INDEX0)
			alarm_next = alarm_value;
		match_next = match_reg;
		if (alarm_clear)
			match_next = 1'b0;
		if (second_tick && mode_reg != hbcc_pkg::HBCC_MODE_RTC && (&field_hit))
			match_next = 1'b1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			mode_reg <= hbcc_pkg::HBCC_MODE_RTC;
			alarm_reg <= '0;
			match_reg <= 1'b0;
		end
		else
		begin
			mode_reg <= mode_next;
			alarm_reg <= alarm_next;
			match_reg <= match_next;
		end
	end

	assign counter_mode = mode_reg;
	assign calendar_mode_24h = (mode_reg == hbcc_pkg::HBCC_MODE_24H);
	assign calendar_mode_12h = (mode_reg == hbcc_pkg::HBCC_MODE_12H);
	assign alarm_match = match_reg;

	// ------------------------------------------------------------
	// Clock source configuration
	// ------------------------------------------------------------
	hbcc_pkg::hbcc_clk_cfg_t cfg_reg, cfg_next;

	always_comb
	begin
		cfg_next = cfg_reg;
		if (clk_cfg_write)
		begin
			cfg_next = clk_cfg_in;
			// At most one drive strength is kept; high wins if both are asked.
			cfg_next.crystal_drive_low = clk_cfg_in.crystal_drive_low & ~clk_cfg_in.crystal_drive_high;
			// With the oscillator running a drive level must exist, so default to high.
			if (!clk_cfg_in.osc_power_down && !clk_cfg_in.crystal_drive_low)
				cfg_next.crystal_drive_high = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cfg_reg <= '{default: 1'b0, crystal_drive_high: 1'b1};
		else
			cfg_reg <= cfg_next;
	end

	assign clk_cfg = cfg_reg;
	assign osc_enable = ~cfg_reg.osc_power_down;
	// The mux is combinational; switching sources may glitch the output clock.
	always_comb
	begin
		if (cfg_reg.select_internal_slow_osc)
			module_clk = internal_low_freq_osc;
		else if (cfg_reg.osc_power_down)
			module_clk = external_osc_input;
		else
			module_clk = crystal_clk;
	end
	assign sys_clk_out = module_clk & cfg_reg.module_clock_to_system;
	generate
		for (gi = 0; gi < ALT_OUTS; gi++)
		begin : g_alt
			assign alt_clk_out[gi] = module_clk & cfg_reg.alt_clock_enable[gi];
		end
	endgenerate
endmodule : hbcc_core

// >>> hbcc_core_chk.sv
// Port checks for the battery, calendar and clock block.
`timescale 1ns/10ps
module hbcc_core_chk #(
	parameter int CHECK_CYCLES = 16
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic force_check,
	input wire logic battery_low_in,
	input wire logic low_battery_int_en,
	input wire logic hibernate_request,
	input wire logic second_tick,
	input wire logic [2:0] mode_sel,
	input wire hbcc_pkg::hbcc_clk_cfg_t clk_cfg,
	input wire logic check_busy,
	input wire logic low_battery_flag,
	input wire logic low_battery_irq,
	input wire logic hibernate_go,
	input wire hbcc_pkg::hbcc_mode_t counter_mode,
	input wire logic alarm_match,
	input wire logic osc_enable
);
	// ----
	// Checks
	// ----
	// A request may park the block, so start checks stop after the first one.
	logic hib_reg;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			hib_reg <= 1'b0;
		else
			hib_reg <= hib_reg | hibernate_request;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_check_start: assert property (force_check && !check_busy && !hib_reg |=> check_busy)
		else $error("forced check did not start");
	a_busy_len: assert property ($rose(check_busy) |-> ##CHECK_CYCLES $fell(check_busy))
		else $error("busy length wrong");
	a_low_set: assert property ($fell(check_busy) && $past(battery_low_in) |-> low_battery_flag)
		else $error("low flag not set");
	a_irq_gate: assert property (low_battery_irq == (low_battery_flag && low_battery_int_en))
		else $error("irq gating wrong");
	a_hib_hold: assert property (check_busy |-> !hibernate_go)
		else $error("hibernate during check");
	a_match_cause: assert property ($rose(alarm_match) |-> $past(second_tick)
		&& $past(counter_mode) != hbcc_pkg::HBCC_MODE_RTC)
		else $error("match without tick");
	a_osc_off: assert property (osc_enable == !clk_cfg.osc_power_down)
		else $error("osc enable wrong");
	a_mode_take: assert property (mode_sel == 3'h2 |=> counter_mode == hbcc_pkg::HBCC_MODE_24H)
		else $error("mode not taken");
	cover property ($fell(check_busy) && low_battery_flag);
	cover property ($rose(alarm_match));
	cover property (hibernate_go);
endmodule : hbcc_core_chk
bind hbcc_core hbcc_core_chk #(.CHECK_CYCLES(CHECK_CYCLES)) chk_u (.*);

// >>> hbcc_core_test.sv
// Self-checking bench for the battery, calendar and clock block.
`timescale 1ns/10ps
module hbcc_core_test;
	logic clk = 1'b0, rst = 1'b1, force_check = 1'b0, battery_low_in = 1'b0;
	logic low_battery_int_en = 1'b0, low_battery_clear = 1'b0, hibernate_request = 1'b0;
	logic second_tick = 1'b0, alarm_write = 1'b0, alarm_clear = 1'b0, clk_cfg_write = 1'b0;
	logic crystal_clk = 1'b0, external_osc_input = 1'b0, internal_low_freq_osc = 1'b0;
	logic [2:0] mode_sel = 3'h1, m = 3'h1;
	logic [1:0] alarm_index = 2'h0, alt_clk_out;
	logic [6:0] e;
	logic mc;
	logic [31:0] r;
	hbcc_pkg::hbcc_cal_t cal_now = '0, alarm_value = '0;
	hbcc_pkg::hbcc_clk_cfg_t clk_cfg_in = '0, clk_cfg;
	hbcc_pkg::hbcc_mode_t counter_mode;
	logic check_busy, measure_enable, low_battery_flag, low_battery_irq, hibernate_go;
	logic calendar_mode_24h, calendar_mode_12h, alarm_match, osc_enable, module_clk, sys_clk_out;
	int mismatches = 0, samples_checked = 0, n, k;
	hbcc_core #(.CHECK_CYCLES(4), .INTERVAL_CYCLES(60000)) dut_u (.*);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t seen %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	initial forever #2.5 clk = ~clk;
	initial
	begin
		#20000;
		mismatches++;
		close_out();
	end
	initial
	begin
		r = $urandom(32'hba2de312);
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		#1 chk({clk_cfg, counter_mode}, 10'h101);
		for (n = 0; n < 2; n++)
		begin
			@(posedge clk);
			battery_low_in <= n[0];
			low_battery_int_en <= r[n];
			force_check <= 1'b1;
			// Held one extra edge so that a request during a check is seen refused.
			repeat (2) @(posedge clk);
			force_check <= 1'b0;
			#1 chk(measure_enable, 1'b1);
			for (k = 0; k < 9 && check_busy === 1'b1; k++) @(posedge clk) #1;
			chk(k, 3);
			chk({low_battery_flag, low_battery_irq}, {n[0], n[0] & r[n]});
			@(posedge clk);
			low_battery_clear <= 1'b1;
			@(posedge clk);
			low_battery_clear <= 1'b0;
			#1 chk(low_battery_flag, 1'b0);
		end
		$display("battery done");
		for (n = 0; n < 8; n++)
		begin
			@(posedge clk);
			mode_sel <= n[2:0];
			if ($onehot(n[2:0]))
				m = n[2:0];
			@(posedge clk);
			#1 chk({counter_mode, calendar_mode_24h, calendar_mode_12h}, {m, m == 3'h2, m == 3'h4});
		end
		$display("mode done");
		for (n = 0; n < 2; n++)
		begin
			r = $urandom | 32'h0101_0101;
			@(posedge clk);
			cal_now <= r;
			alarm_value <= {16'hffff, r[15:0]};
			alarm_index <= {1'b0, ~n[0]};
			alarm_write <= 1'b1;
			@(posedge clk);
			alarm_write <= 1'b0;
			second_tick <= 1'b1;
			@(posedge clk);
			second_tick <= 1'b0;
			#1 chk(alarm_match, n[0]);
		end
		@(posedge clk);
		alarm_clear <= 1'b1;
		@(posedge clk);
		alarm_clear <= 1'b0;
		#1 chk(alarm_match, 1'b0);
		$display("alarm done");
		for (n = 0; n < 6; n++)
		begin
			r = $urandom;
			e = r[6:0];
			if (e[5])
				e[4] = 1'b0;
			if (!e[6] && !e[4])
				e[5] = 1'b1;
			mc = e[3] ? r[9] : (e[6] ? r[8] : r[7]);
			@(posedge clk);
			clk_cfg_in <= r[6:0];
			crystal_clk <= r[7];
			external_osc_input <= r[8];
			internal_low_freq_osc <= r[9];
			clk_cfg_write <= 1'b1;
			@(posedge clk);
			clk_cfg_write <= 1'b0;
			#1 chk({clk_cfg, osc_enable}, {e, ~e[6]});
			chk({module_clk, sys_clk_out, alt_clk_out}, {mc, mc & e[2], mc & e[1], mc & e[0]});
		end
		$display("clock done");
		@(posedge clk);
		force_check <= 1'b1;
		@(posedge clk);
		force_check <= 1'b0;
		hibernate_request <= 1'b1;
		@(posedge clk);
		hibernate_request <= 1'b0;
		for (k = 0; k < 20 && hibernate_go !== 1'b1; k++) @(posedge clk) #1;
		chk(k, 5);
		$display("hibernate done");
		close_out();
	end
endmodule : hbcc_core_test
